/* File: include/rpb_pkg.sv */
// Constants and types shared by the reset, PLL and bias control block
package rpb_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] RPB_ADDR_SOFT_RESET = 8'h00;
    localparam logic [7:0] RPB_ADDR_PLL        = 8'h01;
    localparam logic [7:0] RPB_ADDR_BOOST      = 8'h02;
    localparam logic [7:0] RPB_ADDR_BIAS       = 8'h03;
    localparam logic [7:0] RPB_REG_RESET       = 8'h00;
    localparam logic [7:0] RPB_READ_UNMAPPED   = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int RPB_SRST_BIT      = 7;
    localparam int RPB_LOCK_BIT      = 7;
    localparam int RPB_CLK_SRC_BIT   = 4;
    localparam int RPB_PLL_EN_BIT    = 3;
    localparam int RPB_RATIO_MSB     = 2;
    localparam int RPB_RATIO_LSB     = 0;
    localparam int RPB_RATE_MSB      = 6;
    localparam int RPB_RATE_LSB      = 5;
    localparam int RPB_FSW_BIT       = 4;
    localparam int RPB_VOLT_MSB      = 7;
    localparam int RPB_VOLT_LSB      = 4;
    localparam int RPB_BIAS_EN_BIT   = 0;
    localparam logic [7:0] RPB_PLL_WMASK   = 8'h18;
    localparam logic [7:0] RPB_BOOST_WMASK = 8'h70;
    localparam logic [7:0] RPB_BIAS_WMASK  = 8'hF1;

    // ****************************************
    // Codes
    // ****************************************
    localparam logic [2:0] RPB_RATIO_MAX   = 3'h4;
    localparam logic [1:0] RPB_RATE_32K    = 2'h0;
    localparam logic [1:0] RPB_RATE_44K1   = 2'h1;
    localparam logic [3:0] RPB_VOLT_MAX    = 4'h8;
    localparam logic [4:0] RPB_BOOST_ABOVE = 5'h02;
    localparam logic [5:0] RPB_DIV_32K_HI  = 6'h0C;
    localparam logic [5:0] RPB_DIV_32K_LO  = 6'h16;
    localparam logic [5:0] RPB_DIV_44K_HI  = 6'h10;
    localparam logic [5:0] RPB_DIV_44K_LO  = 6'h1E;
    localparam logic [5:0] RPB_DIV_48K_HI  = 6'h10;
    localparam logic [5:0] RPB_DIV_48K_LO  = 6'h20;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_RAMP = 3'b010,
        ST_RUN  = 3'b100
    } rpb_por_e;
endpackage

/* File: hdl/rpb_ctrl.sv */
// Reset sequencing, PLL clock control and microphone bias control
`timescale 1ns/1ps
`default_nettype none
module rpb_ctrl
    import rpb_pkg::*;
(
    // Clock and reset
    input  wire  logic       clk_sys,
    input  wire  logic       rst_n,
    // Pins and analog monitors
    input  wire  logic       power_down_reset_n,
    input  wire  logic       supply_above_high,
    input  wire  logic       supply_below_low,
    input  wire  logic       master_clock_pin,
    input  wire  logic       frame_clock_pin,
    input  wire  logic       pll_lock_raw,
    // Decoded control port
    input  wire  logic [7:0] reg_addr,
    input  wire  logic [7:0] reg_wdata,
    input  wire  logic       reg_wr,
    input  wire  logic       reg_rd,
    output var   logic [7:0] reg_rdata,
    output var   logic       reg_rvalid,
    // Supply and core control
    output var   logic       regulator_enable,
    output var   logic       core_reset_n,
    // PLL control
    output var   logic       pll_ref_clk,
    output var   logic       pll_enable,
    output var   logic [2:0] clock_ratio_select,
    // Boost and bias control
    output var   logic [1:0] sample_rate_select,
    output var   logic [5:0] step_up_divisor,
    output var   logic       step_up_enable,
    output var   logic [4:0] step_up_output,
    output var   logic [3:0] bias_voltage_select,
    output var   logic       microphone_supply_out
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [5:0] boost_div(input logic [1:0] rate, input logic hi);
        logic [5:0] d;
        d = hi ? RPB_DIV_48K_HI : RPB_DIV_48K_LO;
        if (rate == RPB_RATE_32K) begin
            d = hi ? RPB_DIV_32K_HI : RPB_DIV_32K_LO;
        end else if (rate == RPB_RATE_44K1) begin
            d = hi ? RPB_DIV_44K_HI : RPB_DIV_44K_LO;
        end
        return d;
    endfunction

    function automatic logic [3:0] volt_clamp(input logic [3:0] code);
        return (code > RPB_VOLT_MAX) ? RPB_VOLT_MAX : code;
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [5:0] sync_a, sync_b;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {pll_lock_raw, frame_clock_pin, master_clock_pin,
                       supply_below_low, supply_above_high, power_down_reset_n};
            sync_b <= sync_a;
        end
    end
    logic pin_high, above_hi, below_lo, mclk_s, fclk_s, lock_s;
    assign {lock_s, fclk_s, mclk_s, below_lo, above_hi, pin_high} = sync_b;

    // ****************************************
    // Power-on reset sequencing
    // ****************************************
    rpb_por_e por_state;
    rpb_por_e next_por_state;
    always_comb begin
        next_por_state = por_state;
        case (por_state)
            ST_OFF: begin
                if (pin_high) begin
                    next_por_state = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (!pin_high) begin
                    next_por_state = ST_OFF;
                end else if (above_hi) begin
                    next_por_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // Hysteresis: a dip above the low trip is ignored
                if (below_lo) begin
                    next_por_state = pin_high ? ST_RAMP : ST_OFF;
                end
            end
            default: next_por_state = ST_OFF;
        endcase
    end

    // ****************************************
    // Register file
    // ****************************************
    logic       srst, next_srst, next_rvalid, core_up, wr_ok;
    logic [7:0] pll_reg, next_pll_reg, boost_reg, next_boost_reg;
    logic [7:0] bias_reg, next_bias_reg, next_rdata;

    assign core_up = (por_state == ST_RUN);
    // Writes before the core is out of reset or during a soft reset are dropped; reads only before power-up ends
    assign wr_ok   = reg_wr && core_up && !srst;

    always_comb begin
        next_srst      = 1'b0;
        next_pll_reg   = pll_reg;
        next_boost_reg = boost_reg;
        next_bias_reg  = bias_reg;
        if (srst || !core_up) begin
            next_pll_reg   = RPB_REG_RESET;
            next_boost_reg = RPB_REG_RESET;
            next_bias_reg  = RPB_REG_RESET;
        end else if (wr_ok) begin
            case (reg_addr)
                RPB_ADDR_SOFT_RESET: next_srst = reg_wdata[RPB_SRST_BIT];
                RPB_ADDR_PLL: begin
                    next_pll_reg = (pll_reg & ~RPB_PLL_WMASK) | (reg_wdata & RPB_PLL_WMASK);
                    // Reserved ratio codes keep the previous ratio
                    if (reg_wdata[RPB_RATIO_MSB:RPB_RATIO_LSB] <= RPB_RATIO_MAX) begin
                        next_pll_reg[RPB_RATIO_MSB:RPB_RATIO_LSB] =
                            reg_wdata[RPB_RATIO_MSB:RPB_RATIO_LSB];
                    end
                end
                RPB_ADDR_BOOST: next_boost_reg = reg_wdata & RPB_BOOST_WMASK;
                RPB_ADDR_BIAS:  next_bias_reg  = reg_wdata & RPB_BIAS_WMASK;
                default: ;
            endcase
        end
    end

    always_comb begin
        next_rvalid = reg_rd && core_up;
        next_rdata  = RPB_READ_UNMAPPED;
        if (reg_rd && core_up) begin
            case (reg_addr)
                RPB_ADDR_SOFT_RESET: next_rdata = {srst, 7'h00};
                RPB_ADDR_PLL: begin
                    next_rdata = pll_reg;
                    next_rdata[RPB_LOCK_BIT] = lock_s;
                end
                RPB_ADDR_BOOST:      next_rdata = boost_reg;
                RPB_ADDR_BIAS:       next_rdata = bias_reg;
                default:             next_rdata = RPB_READ_UNMAPPED;
            endcase
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            por_state             <= ST_OFF;
            srst                  <= 1'b0;
            pll_reg               <= RPB_REG_RESET;
            boost_reg             <= RPB_REG_RESET;
            bias_reg              <= RPB_REG_RESET;
            reg_rdata             <= RPB_READ_UNMAPPED;
            reg_rvalid            <= 1'b0;
            regulator_enable      <= 1'b0;
            core_reset_n          <= 1'b0;
            pll_ref_clk           <= 1'b0;
            pll_enable            <= 1'b0;
            clock_ratio_select    <= 3'h0;
            sample_rate_select    <= 2'h0;
            step_up_divisor       <= RPB_DIV_32K_LO;
            step_up_enable        <= 1'b0;
            step_up_output        <= 5'h00;
            bias_voltage_select   <= 4'h0;
            microphone_supply_out <= 1'b0;
        end else begin
            por_state             <= next_por_state;
            srst                  <= next_srst;
            pll_reg               <= next_pll_reg;
            boost_reg             <= next_boost_reg;
            bias_reg              <= next_bias_reg;
            reg_rdata             <= next_rdata;
            reg_rvalid            <= next_rvalid;
            regulator_enable      <= pin_high;
            core_reset_n          <= (next_por_state == ST_RUN) && !next_srst;
            pll_ref_clk           <= pll_reg[RPB_CLK_SRC_BIT] ? fclk_s : mclk_s;
            pll_enable            <= pll_reg[RPB_PLL_EN_BIT];
            clock_ratio_select    <= pll_reg[RPB_RATIO_MSB:RPB_RATIO_LSB];
            sample_rate_select    <= boost_reg[RPB_RATE_MSB:RPB_RATE_LSB];
            step_up_divisor       <= boost_div(boost_reg[RPB_RATE_MSB:RPB_RATE_LSB],
                                               boost_reg[RPB_FSW_BIT]);
            // Boost runs only with the PLL, its only clock source
            step_up_enable        <= bias_reg[RPB_BIAS_EN_BIT] && pll_reg[RPB_PLL_EN_BIT];
            step_up_output        <= {1'b0, volt_clamp(bias_reg[RPB_VOLT_MSB:RPB_VOLT_LSB])}
                                     + RPB_BOOST_ABOVE;
            bias_voltage_select   <= volt_clamp(bias_reg[RPB_VOLT_MSB:RPB_VOLT_LSB]);
            microphone_supply_out <= bias_reg[RPB_BIAS_EN_BIT];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_reg_follows_pin;
        @(posedge clk_sys) disable iff (!rst_n) regulator_enable == $past(sync_b[0]);
    endproperty
    a_reg_follows_pin: assert property (p_reg_follows_pin) else $error("regulator wrong");
    // Judged on the state change: a soft reset may end below the high trip
    property p_core_needs_high;
        @(posedge clk_sys) disable iff (!rst_n)
            (core_reset_n |-> core_up)
            and ($rose(core_up) |-> $past(above_hi) && $past(pin_high));
    endproperty
    a_core_needs_high: assert property (p_core_needs_high) else $error("early release");
    property p_hysteresis;
        @(posedge clk_sys) disable iff (!rst_n)
            (core_up && !below_lo && !srst && !next_srst) |=> core_reset_n;
    endproperty
    a_hysteresis: assert property (p_hysteresis) else $error("glitch reset");
    property p_srst;
        @(posedge clk_sys) disable iff (!rst_n)
            (wr_ok && reg_addr == RPB_ADDR_SOFT_RESET && reg_wdata[RPB_SRST_BIT])
            |=> srst ##1 (!srst && pll_reg == RPB_REG_RESET && bias_reg == RPB_REG_RESET);
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset failed");
    property p_ref_sel;
        @(posedge clk_sys) disable iff (!rst_n)
            pll_ref_clk == ($past(pll_reg[RPB_CLK_SRC_BIT]) ? $past(fclk_s) : $past(mclk_s));
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("reference mux");
    property p_ratio_legal;
        @(posedge clk_sys) disable iff (!rst_n) clock_ratio_select <= RPB_RATIO_MAX;
    endproperty
    a_ratio_legal: assert property (p_ratio_legal) else $error("reserved ratio");
    property p_lock_read;
        @(posedge clk_sys) disable iff (!rst_n)
            (reg_rd && core_up && reg_addr == RPB_ADDR_PLL)
            |=> reg_rvalid && reg_rdata[RPB_LOCK_BIT] == $past(lock_s);
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock status");
    property p_divisor;
        @(posedge clk_sys) disable iff (!rst_n)
            (boost_reg[RPB_RATE_MSB:RPB_RATE_LSB] == RPB_RATE_32K && boost_reg[RPB_FSW_BIT])
            |=> step_up_divisor == RPB_DIV_32K_HI;
    endproperty
    a_divisor: assert property (p_divisor) else $error("boost divisor");
    // Both outputs clear in reset, so the offset only holds from the second edge on
    property p_boost_above;
        @(posedge clk_sys) disable iff (!rst_n)
            $past(rst_n) |-> step_up_output == {1'b0, bias_voltage_select} + RPB_BOOST_ABOVE
            && bias_voltage_select <= RPB_VOLT_MAX;
    endproperty
    a_boost_above: assert property (p_boost_above) else $error("boost level");
    property p_bias_en;
        @(posedge clk_sys) disable iff (!rst_n)
            microphone_supply_out == $past(bias_reg[RPB_BIAS_EN_BIT]);
    endproperty
    a_bias_en: assert property (p_bias_en) else $error("bias enable");

    c_power_up:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(core_reset_n));
    c_soft_rst:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(srst));
    c_frame_ref: cover property (@(posedge clk_sys) disable iff (!rst_n)
                                 pll_enable && pll_reg[RPB_CLK_SRC_BIT]);
    c_bias_on:   cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(microphone_supply_out));
endmodule
`default_nettype wire

/* File: sim/rpb_host_model.sv */
// Host controller model driving the decoded register port
`timescale 1ns/1ps
`default_nettype none
module rpb_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // ****************************************
    // Bus cycles
    // ****************************************
    int gap = 0;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Idle lines flip so a stale address or datum never looks valid
    task automatic idle();
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        repeat (gap) @(negedge clk_sys);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        idle();
    endtask

    // One-cycle strobe; the answer stands for one cycle after the taking edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        repeat (gap) @(negedge clk_sys);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk_sys);
        idle();
        d  = reg_rdata;
        ok = reg_rvalid;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the reset, PLL and bias control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import rpb_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       rst_n, power_down_reset_n, supply_above_high, supply_below_low;
    logic       master_clock_pin, frame_clock_pin, pll_lock_raw, ok;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, pll_m, bst_m, bias_m, d;
    logic       reg_wr, reg_rd, reg_rvalid, regulator_enable, core_reset_n;
    logic       pll_ref_clk, pll_enable, step_up_enable, microphone_supply_out;
    logic [2:0] clock_ratio_select;
    logic [1:0] sample_rate_select;
    logic [5:0] step_up_divisor;
    logic [4:0] step_up_output;
    logic [3:0] bias_voltage_select;
    int         errors = 0;
    int         samples_checked = 0;
    int         seed = 16248;

    always #5 clk_sys = ~clk_sys;

    rpb_ctrl dut (.clk_sys, .rst_n, .power_down_reset_n, .supply_above_high,
        .supply_below_low, .master_clock_pin, .frame_clock_pin, .pll_lock_raw, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .regulator_enable,
        .core_reset_n, .pll_ref_clk, .pll_enable, .clock_ratio_select, .sample_rate_select,
        .step_up_divisor, .step_up_enable, .step_up_output, .bias_voltage_select,
        .microphone_supply_out);
    rpb_host_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid);

    // ****************************************
    // Checks and expectations
    // ****************************************
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [5:0] exp_div(input logic [7:0] b);
        logic hi;
        hi = b[RPB_FSW_BIT];
        case (b[RPB_RATE_MSB:RPB_RATE_LSB])
            RPB_RATE_32K:  return hi ? RPB_DIV_32K_HI : RPB_DIV_32K_LO;
            RPB_RATE_44K1: return hi ? RPB_DIV_44K_HI : RPB_DIV_44K_LO;
            default:       return hi ? RPB_DIV_48K_HI : RPB_DIV_48K_LO;
        endcase
    endfunction

    task automatic check_outputs();
        logic [3:0] v;
        v = (bias_m[7:4] > RPB_VOLT_MAX) ? RPB_VOLT_MAX : bias_m[7:4];
        check("pll_enable", 8'(pll_m[RPB_PLL_EN_BIT]), 8'(pll_enable));
        check("clock_ratio_select", 8'(pll_m[2:0]), 8'(clock_ratio_select));
        check("pll_ref_clk", 8'(pll_m[RPB_CLK_SRC_BIT] ? frame_clock_pin : master_clock_pin),
            8'(pll_ref_clk));
        check("sample_rate_select", 8'(bst_m[6:5]), 8'(sample_rate_select));
        check("step_up_divisor", 8'(exp_div(bst_m)), 8'(step_up_divisor));
        check("bias_voltage_select", 8'(v), 8'(bias_voltage_select));
        check("step_up_output", 8'(v) + 8'(RPB_BOOST_ABOVE), 8'(step_up_output));
        check("microphone_supply_out", 8'(bias_m[0]), 8'(microphone_supply_out));
        check("step_up_enable", 8'(bias_m[0] & pll_m[3]), 8'(step_up_enable));
    endtask

    task automatic wait_core(input logic lvl);
        int n;
        n = 0;
        while (core_reset_n !== lvl && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("core_reset_n", 8'(lvl), 8'(core_reset_n));
        if (n == 20) begin
            final_report();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        host.read_reg(a, rd_v, ok);
        check("reg_rvalid", 8'h01, 8'(ok));
        check("read data", exp & m, rd_v & m);
    endtask

    // Model keeps what the registers should hold; reserved ratio codes are dropped
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.write_reg(a, v);
        if (a == RPB_ADDR_PLL) begin
            pll_m[4:3] = v[4:3];
            if (v[2:0] <= RPB_RATIO_MAX) pll_m[2:0] = v[2:0];
        end
        if (a == RPB_ADDR_BOOST) bst_m = v & RPB_BOOST_WMASK;
        if (a == RPB_ADDR_BIAS) bias_m = v & RPB_BIAS_WMASK;
        repeat (3) @(negedge clk_sys);
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n              = 1'b0;
        power_down_reset_n = 1'b0;
        supply_above_high  = 1'b0;
        supply_below_low   = 1'b1;
        master_clock_pin   = 1'b0;
        frame_clock_pin    = 1'b0;
        pll_lock_raw       = 1'b0;
        pll_m              = 8'h00;
        bst_m              = 8'h00;
        bias_m             = 8'h00;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("regulator_enable", 8'h00, 8'(regulator_enable));
        check_outputs();
        host.read_reg(RPB_ADDR_BIAS, rd_v, ok);
        check("reg_rvalid", 8'h00, 8'(ok));
        $display("test reset defaults done");
        power_down_reset_n = 1'b1;
        supply_below_low   = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("regulator_enable", 8'h01, 8'(regulator_enable));
        check("core_reset_n", 8'h00, 8'(core_reset_n));
        supply_above_high = 1'b1;
        wait_core(1'b1);
        repeat (20) @(negedge clk_sys);
        rd(RPB_ADDR_PLL, 8'h00, 8'h80);
        $display("test power up done");
        for (int c = 0; c < 16; c++) begin
            wr(RPB_ADDR_PLL, {3'h0, c[3], 1'b1, c[2:0]});
            wr(RPB_ADDR_BOOST, {1'b0, c[2:0], 4'h0});
            wr(RPB_ADDR_BIAS, {c[3:0], 3'h0, c[0]});
            check_outputs();
        end
        $display("test code sweep done");
        for (int i = 0; i < 40; i++) begin
            master_clock_pin = 1'($random(seed));
            frame_clock_pin  = ~master_clock_pin;
            pll_lock_raw     = 1'($random(seed));
            host.gap         = $random(seed) & 3;
            d                = 8'($random(seed));
            wr(RPB_ADDR_PLL, pll_m & 8'hF7);
            wr(RPB_ADDR_PLL, d & 8'hF7);
            wr(RPB_ADDR_PLL, d);
            wr(RPB_ADDR_BOOST, 8'($random(seed)));
            wr(RPB_ADDR_BIAS, 8'($random(seed)));
            check_outputs();
            rd(RPB_ADDR_PLL, {pll_lock_raw, pll_m[6:0]}, 8'hFF);
            rd(RPB_ADDR_BOOST, bst_m, 8'hFF);
            rd(RPB_ADDR_BIAS, bias_m, (bias_m[7:4] > RPB_VOLT_MAX) ? 8'h0F : 8'hFF);
        end
        wr(8'h05, 8'hFF);
        check_outputs();
        rd(8'h07, RPB_READ_UNMAPPED, 8'hFF);
        $display("test random config done");
        supply_above_high = 1'b0;
        repeat (8) @(negedge clk_sys);
        check("core_reset_n", 8'h01, 8'(core_reset_n));
        power_down_reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("regulator_enable", 8'h00, 8'(regulator_enable));
        check("core_reset_n", 8'h01, 8'(core_reset_n));
        supply_below_low = 1'b1;
        wait_core(1'b0);
        pll_m              = 8'h00;
        bst_m              = 8'h00;
        bias_m             = 8'h00;
        power_down_reset_n = 1'b1;
        supply_below_low   = 1'b0;
        supply_above_high  = 1'b1;
        wait_core(1'b1);
        check_outputs();
        $display("test hysteresis done");
        wr(RPB_ADDR_BOOST, 8'h70);
        wr(RPB_ADDR_BIAS, 8'hF1);
        host.write_reg(RPB_ADDR_SOFT_RESET, 8'h80);
        check("core_reset_n", 8'h00, 8'(core_reset_n));
        bst_m  = 8'h00;
        bias_m = 8'h00;
        repeat (3) @(negedge clk_sys);
        check("core_reset_n", 8'h01, 8'(core_reset_n));
        check_outputs();
        rd(RPB_ADDR_SOFT_RESET, 8'h00, 8'hFF);
        rd(RPB_ADDR_BIAS, 8'h00, 8'hFF);
        $display("test soft reset done");
        final_report();
    end
endmodule
`default_nettype wire
